// file: eic_channel.sv
`timescale 1ns/1ps
`default_nettype none
module eic_channel (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [eic_pkg::PORT_W-1:0] pins,
    input wire eic_pkg::eic_chan_cfg_t cfg,
    input wire logic vectorAck,
    input wire logic swWrite,
    input wire logic swValue,
    output logic pending,
    output logic edgeEvent
);
    import eic_pkg::*;

    typedef struct packed {
        logic wasActive;
        logic pend;
        logic evt;
    } eic_chan_state_t;

    eic_chan_state_t s_q;
    eic_chan_state_t s_d;
    logic active;
    logic rise;

    always_comb begin
        s_d = s_q;
        active = cfg.polarity ? pins[cfg.pinSel] : ~pins[cfg.pinSel];
        rise = active & ~s_q.wasActive;
        s_d.wasActive = active;
        s_d.evt = rise;
        if (cfg.edgeMode) begin
            if (swWrite) begin
                s_d.pend = swValue;
            end
            if (vectorAck) begin
                s_d.pend = 1'b0;
            end
            // A new edge in the clearing cycle is kept rather than lost.
            if (rise) begin
                s_d.pend = 1'b1;
            end
        end else begin
            s_d.pend = active;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            // Starting as active stops a pin already active at reset from faking an edge.
            s_q <= '{wasActive: 1'b1, pend: 1'b0, evt: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign pending = s_q.pend;
    assign edgeEvent = s_q.evt;
endmodule
`default_nettype wire

// file: eic_checker.sv
`timescale 1ns/1ps
`default_nettype none
module eic_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire eic_pkg::eic_apb_req_t apbReq,
    input wire eic_pkg::eic_apb_rsp_t apbRsp,
    input wire logic [eic_pkg::PORT_W-1:0] portPins,
    input wire logic portMatchIn,
    input wire logic [1:0] vectorAck,
    input wire eic_pkg::eic_cpu_req_t cpuReq,
    input wire logic [eic_pkg::PORT_W-1:0] crossbarSkip,
    input wire logic irq
);
    import eic_pkg::*;
    logic done;
    logic prioWr;
    logic skipWr;
    assign done = apbReq.psel & apbReq.penable & apbRsp.pready;
    assign prioWr = done & apbReq.pwrite & (apbReq.paddr == 12'h33c);
    assign skipWr = done & apbReq.pwrite & (apbReq.paddr == 12'h3c4);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_setup;
        apbReq.psel && !apbReq.penable;
    endsequence
    sequence s_access;
        apbReq.psel && apbReq.penable;
    endsequence
    a_ready_timing: assert property (s_setup ##1 s_access |-> ##1 apbRsp.pready)
        else $error("pready not on time");
    a_ready_pulse: assert property (apbRsp.pready |=> !apbRsp.pready)
        else $error("pready too long");
    a_err_ready: assert property (apbRsp.pslverr |-> apbRsp.pready)
        else $error("stray pslverr");
    a_upper_zero: assert property (done && !apbReq.pwrite |-> apbRsp.prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_match_masked: assert property (cpuReq.matchReq |-> $past(portMatchIn))
        else $error("match request without input");
    a_prio_written: assert property ($changed(cpuReq.matchHighPrio) |->
        $past(prioWr) || $past(prioWr, 2)) else $error("priority moved alone");
    a_unused_zero: assert property (done && !apbReq.pwrite &&
        (apbReq.paddr == 12'h33c || apbReq.paddr == 12'h39c) |->
        (apbRsp.prdata & ~32'h2) == 32'h0) else $error("unused bit set");
    a_skip_written: assert property ($changed(crossbarSkip) |->
        $past(skipWr) || $past(skipWr, 2)) else $error("skip moved alone");
    a_irq_drop: assert property ($fell(irq) |-> $past(done) || $past(done, 2))
        else $error("irq fell alone");
endmodule
bind eic_top eic_checker chk (.clk_sys(clk_sys), .rst(rst), .apbReq(apbReq),
    .apbRsp(apbRsp), .portPins(portPins), .portMatchIn(portMatchIn),
    .vectorAck(vectorAck), .cpuReq(cpuReq), .crossbarSkip(crossbarSkip), .irq(irq));
`default_nettype wire

// file: eic_irq_source.sv
`timescale 1ns/1ps
`default_nettype none
module eic_irq_source (
    input wire logic clk_sys,
    input wire logic [7:0] fire,
    input wire logic [7:0] drop,
    input wire logic [7:0] activeHigh,
    output logic [7:0] pins
);
    logic [7:0] active_q = 8'h00;
    always_ff @(posedge clk_sys) begin
        active_q <= fire | (active_q & ~drop);
    end
    // Idle pins sit inactive, so a new pin selection never sees a false edge.
    assign pins = ~(active_q ^ activeHigh);
endmodule
`default_nettype wire

// file: eic_pkg.sv
// Notes on behaviour
// - The port-match request passes only while its enable bit is 1 and is masked while it is 0.
// - The port-match request carries high priority when its priority bit is 1, low when 0.
// - Unused bits of the port-match enable and priority registers read as zero and ignore writes.
// - Each external input is edge-sensitive when its select bit is 1 and level-sensitive when 0.
// - Each external input is active low when its polarity bit is 0 and active high when 1.
// - A three-bit pin select connects each external input to the port 0 pin of that index.
// - The selected pin is only sampled, never driven, so a crossbar peripheral on it is untouched.
// - A port pin whose skip bit is 1 is withheld from the crossbar peripherals.
// - Pending flags sit at bit 1 (input A) and bit 3 (input B) of the timer control register.
// - In edge mode a pending flag clears when the CPU vectors to its service routine.
// - In level mode a pending flag reads 1 while the input is active and 0 while inactive.
`default_nettype none
package eic_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int PORT_W = 8;
    localparam int SEL_W = 3;
    localparam int EVT_W = 3;

    localparam logic [9:0] IDX_PM_PRIO = 10'h0cf;
    localparam logic [9:0] IDX_PIN_CFG = 10'h0e4;
    localparam logic [9:0] IDX_PM_EN = 10'h0e7;
    localparam logic [9:0] IDX_TIMER_CTL = 10'h0f0;
    localparam logic [9:0] IDX_SKIP = 10'h0f1;
    localparam logic [9:0] IDX_EXT_EN = 10'h0f2;
    localparam logic [9:0] IDX_STATUS = 10'h0f3;
    localparam logic [9:0] IDX_MASK = 10'h0f4;

    localparam logic [7:0] RST_PIN_CFG = 8'h01;
    localparam logic [7:0] RST_ZERO = 8'h00;

    localparam int PM_EN_BIT = 1;
    localparam int PM_PRIO_BIT = 1;
    localparam int A_EDGE_BIT = 0;
    localparam int A_PEND_BIT = 1;
    localparam int B_EDGE_BIT = 2;
    localparam int B_PEND_BIT = 3;
    localparam int A_SEL_LSB = 0;
    localparam int A_POL_BIT = 3;
    localparam int B_SEL_LSB = 4;
    localparam int B_POL_BIT = 7;
    localparam int EVT_A = 0;
    localparam int EVT_B = 1;
    localparam int EVT_PM = 2;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } eic_apb_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } eic_apb_rsp_t;

    typedef struct packed {
        logic edgeMode;
        logic polarity;
        logic [SEL_W-1:0] pinSel;
    } eic_chan_cfg_t;

    typedef struct packed {
        logic extAReq;
        logic extBReq;
        logic matchReq;
        logic matchHighPrio;
    } eic_cpu_req_t;
endpackage
`default_nettype wire

// file: eic_top.sv
`timescale 1ns/1ps
`default_nettype none
module eic_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire eic_pkg::eic_apb_req_t apbReq,
    output eic_pkg::eic_apb_rsp_t apbRsp,
    input wire logic [eic_pkg::PORT_W-1:0] portPins,
    input wire logic portMatchIn,
    input wire logic [1:0] vectorAck,
    output eic_pkg::eic_cpu_req_t cpuReq,
    output logic [eic_pkg::PORT_W-1:0] crossbarSkip,
    output logic irq
);
    import eic_pkg::*;

    typedef struct packed {
        logic [PORT_W-1:0] syncA;
        logic [PORT_W-1:0] syncB;
        logic [7:0] pmEnable;
        logic [7:0] pmPriority;
        logic [7:0] pinCfg;
        logic edgeA;
        logic edgeB;
        logic [PORT_W-1:0] skip;
        logic [1:0] extEnable;
        logic [EVT_W-1:0] status;
        logic [EVT_W-1:0] mask;
        logic matchPrev;
        eic_apb_rsp_t rsp;
        eic_cpu_req_t req;
        logic irq;
    } eic_state_t;

    eic_state_t s_q;
    eic_state_t s_d;
    logic pendA;
    logic pendB;
    logic evtA;
    logic evtB;
    logic access;
    logic commit;
    logic wrCommit;
    logic rdCommit;
    logic hit;
    logic [DATA_W-1:0] rdValue;
    logic [7:0] wbyte;
    logic [EVT_W-1:0] events;
    eic_chan_cfg_t cfgA;
    eic_chan_cfg_t cfgB;

    function automatic logic isAddr(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
        isAddr = (a == {idx, 2'b00});
    endfunction

    // the pins are only read here.
    always_comb begin
        cfgA.edgeMode = s_q.edgeA;
        cfgA.polarity = s_q.pinCfg[A_POL_BIT];
        cfgA.pinSel = s_q.pinCfg[A_SEL_LSB +: SEL_W];
        cfgB.edgeMode = s_q.edgeB;
        cfgB.polarity = s_q.pinCfg[B_POL_BIT];
        cfgB.pinSel = s_q.pinCfg[B_SEL_LSB +: SEL_W];
    end

    // Register read decode.
    always_comb begin
        hit = 1'b1;
        rdValue = '0;
        if (isAddr(apbReq.paddr, IDX_PM_EN)) begin
            rdValue[PM_EN_BIT] = s_q.pmEnable[PM_EN_BIT];
        end else if (isAddr(apbReq.paddr, IDX_PM_PRIO)) begin
            rdValue[PM_PRIO_BIT] = s_q.pmPriority[PM_PRIO_BIT];
        end else if (isAddr(apbReq.paddr, IDX_PIN_CFG)) begin
            rdValue[7:0] = s_q.pinCfg;
        end else if (isAddr(apbReq.paddr, IDX_TIMER_CTL)) begin
            rdValue[A_EDGE_BIT] = s_q.edgeA;
            rdValue[A_PEND_BIT] = pendA;
            rdValue[B_EDGE_BIT] = s_q.edgeB;
            rdValue[B_PEND_BIT] = pendB;
        end else if (isAddr(apbReq.paddr, IDX_SKIP)) begin
            rdValue[PORT_W-1:0] = s_q.skip;
        end else if (isAddr(apbReq.paddr, IDX_EXT_EN)) begin
            rdValue[1:0] = s_q.extEnable;
        end else if (isAddr(apbReq.paddr, IDX_STATUS)) begin
            rdValue[EVT_W-1:0] = s_q.status;
        end else if (isAddr(apbReq.paddr, IDX_MASK)) begin
            rdValue[EVT_W-1:0] = s_q.mask;
        end else begin
            hit = 1'b0;
        end
    end

    // The answer is registered, so every access phase lasts exactly two cycles.
    assign access = apbReq.psel & apbReq.penable;
    assign commit = access & s_q.rsp.pready;
    assign wrCommit = commit & apbReq.pwrite & hit;
    assign rdCommit = commit & ~apbReq.pwrite & hit;
    assign wbyte = apbReq.pwdata[7:0];

    eic_channel u_chanA (
        .clk_sys(clk_sys),
        .rst(rst),
        .pins(s_q.syncB),
        .cfg(cfgA),
        .vectorAck(vectorAck[0]),
        .swWrite(wrCommit & isAddr(apbReq.paddr, IDX_TIMER_CTL)),
        .swValue(wbyte[A_PEND_BIT]),
        .pending(pendA),
        .edgeEvent(evtA)
    );

    eic_channel u_chanB (
        .clk_sys(clk_sys),
        .rst(rst),
        .pins(s_q.syncB),
        .cfg(cfgB),
        .vectorAck(vectorAck[1]),
        .swWrite(wrCommit & isAddr(apbReq.paddr, IDX_TIMER_CTL)),
        .swValue(wbyte[B_PEND_BIT]),
        .pending(pendB),
        .edgeEvent(evtB)
    );

    always_comb begin
        s_d = s_q;
        s_d.syncA = portPins;
        s_d.syncB = s_q.syncA;
        s_d.matchPrev = portMatchIn;
        events = '0;
        events[EVT_A] = evtA;
        events[EVT_B] = evtB;
        events[EVT_PM] = portMatchIn & ~s_q.matchPrev;

        if (access && !s_q.rsp.pready) begin
            s_d.rsp.pready = 1'b1;
            s_d.rsp.prdata = apbReq.pwrite ? '0 : rdValue;
            s_d.rsp.pslverr = ~hit;
        end else begin
            s_d.rsp.pready = 1'b0;
            s_d.rsp.pslverr = 1'b0;
        end

        if (wrCommit) begin
            if (isAddr(apbReq.paddr, IDX_PM_EN)) begin
                // only the defined bit is written.
                s_d.pmEnable[PM_EN_BIT] = wbyte[PM_EN_BIT];
            end else if (isAddr(apbReq.paddr, IDX_PM_PRIO)) begin
                s_d.pmPriority[PM_PRIO_BIT] = wbyte[PM_PRIO_BIT];
            end else if (isAddr(apbReq.paddr, IDX_PIN_CFG)) begin
                s_d.pinCfg = wbyte;
            end else if (isAddr(apbReq.paddr, IDX_TIMER_CTL)) begin
                s_d.edgeA = wbyte[A_EDGE_BIT];
                s_d.edgeB = wbyte[B_EDGE_BIT];
            end else if (isAddr(apbReq.paddr, IDX_SKIP)) begin
                s_d.skip = wbyte[PORT_W-1:0];
            end else if (isAddr(apbReq.paddr, IDX_EXT_EN)) begin
                s_d.extEnable = wbyte[1:0];
            end else if (isAddr(apbReq.paddr, IDX_MASK)) begin
                s_d.mask = wbyte[EVT_W-1:0];
            end
        end

        // Reading the status clears it, but an event in the same cycle survives.
        if (rdCommit && isAddr(apbReq.paddr, IDX_STATUS)) begin
            s_d.status = events;
        end else begin
            s_d.status = s_q.status | events;
        end
        s_d.irq = |(s_d.status & s_d.mask);

        s_d.req.extAReq = pendA & s_q.extEnable[0];
        s_d.req.extBReq = pendB & s_q.extEnable[1];
        s_d.req.matchReq = portMatchIn & s_q.pmEnable[PM_EN_BIT];
        s_d.req.matchHighPrio = s_q.pmPriority[PM_PRIO_BIT];
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '0;
            s_q.pinCfg <= RST_PIN_CFG;
            s_q.pmEnable <= RST_ZERO;
            s_q.pmPriority <= RST_ZERO;
            s_q.skip <= RST_ZERO;
        end else begin
            s_q <= s_d;
        end
    end

    assign apbRsp = s_q.rsp;
    assign cpuReq = s_q.req;
    // skipped pins held back from the crossbar.
    assign crossbarSkip = s_q.skip;
    assign irq = s_q.irq;
endmodule
`default_nettype wire

// file: test_external_interrupt_config.sv
`timescale 1ns/1ps
`default_nettype none
module test_external_interrupt_config;
    import eic_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    eic_apb_req_t apbReq = '0;
    eic_apb_rsp_t apbRsp;
    eic_cpu_req_t cpuReq;
    logic [7:0] portPins, crossbarSkip;
    logic [7:0] fire = 8'h00, drop = 8'h00, activeHigh = 8'hff;
    logic portMatchIn = 1'b0;
    logic [1:0] vectorAck = 2'b00;
    logic irq, err;
    logic [31:0] rd;
    int fails = 0, checks_done = 0;
    always #25 clk_sys = ~clk_sys;
    eic_top uut (.clk_sys(clk_sys), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
        .portPins(portPins), .portMatchIn(portMatchIn), .vectorAck(vectorAck),
        .cpuReq(cpuReq), .crossbarSkip(crossbarSkip), .irq(irq));
    eic_irq_source src (.clk_sys(clk_sys), .fire(fire), .drop(drop),
        .activeHigh(activeHigh), .pins(portPins));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        apbReq <= {1'b1, 1'b0, w, a, d};
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (apbRsp.pready !== 1'b1 && n < 20);
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq <= '0;
        if (n >= 20) fails++;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #(50 * 20000);
        fails++;
        give_verdict();
    end
    initial begin
        tick(12);
        rst <= 1'b0;
        rchk(12'h390, 32'h1);
        rchk(12'h3c0, 32'ha);
        rchk(12'h33c, 32'h0);
        rchk(12'h39c, 32'h0);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, i ? 12'h39c : 12'h33c, 32'hffffffff);
            rchk(i ? 12'h39c : 12'h33c, 32'h2);
        end
        portMatchIn <= 1'b1;
        tick(3);
        chk(cpuReq.matchReq, 1);
        chk(cpuReq.matchHighPrio, 1);
        apb(1'b1, 12'h39c, 32'h0);
        apb(1'b1, 12'h33c, 32'h0);
        tick(3);
        chk(cpuReq.matchReq, 0);
        chk(cpuReq.matchHighPrio, 0);
        rchk(12'h3cc, 32'h4);
        apb(1'b1, 12'h3c4, 32'h81);
        tick(2);
        chk(crossbarSkip, 8'h81);
        apb(1'b0, 12'h004, 32'h0);
        chk(err, 1);
        chk(rd, 0);
        apb(1'b1, 12'h3c8, 32'h3);
        apb(1'b1, 12'h390, 32'hf8);
        rchk(12'h3c0, 32'h0);
        apb(1'b1, 12'h3c0, 32'h1);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, 12'h390, 32'hf8 | i);
            fire <= 8'h1 << i;
            tick(1);
            fire <= 8'h0;
            tick(6);
            chk(cpuReq.extAReq, 1);
            drop <= 8'h1 << i;
            tick(1);
            drop <= 8'h0;
            tick(6);
            rchk(12'h3c0, 32'h3);
            vectorAck <= 2'b01;
            tick(1);
            vectorAck <= 2'b00;
            tick(2);
            rchk(12'h3c0, 32'h1);
            chk(irq, 0);
        end
        apb(1'b1, 12'h390, 32'h87);
        activeHigh <= 8'h7f;
        tick(6);
        vectorAck <= 2'b01;
        tick(1);
        vectorAck <= 2'b00;
        apb(1'b0, 12'h3cc, 32'h0);
        apb(1'b1, 12'h3d0, 32'h1);
        fire <= 8'h80;
        tick(1);
        fire <= 8'h0;
        tick(6);
        chk(irq, 1);
        rchk(12'h3c0, 32'h3);
        rchk(12'h3cc, 32'h1);
        tick(2);
        chk(irq, 0);
        rchk(12'h3cc, 32'h0);
        apb(1'b1, 12'h390, 32'h78);
        drop <= 8'h80;
        vectorAck <= 2'b01;
        tick(1);
        drop <= 8'h0;
        vectorAck <= 2'b00;
        tick(6);
        fire <= 8'h80;
        tick(1);
        fire <= 8'h0;
        tick(6);
        rchk(12'h3c0, 32'h9);
        chk(cpuReq.extBReq, 1);
        drop <= 8'h80;
        tick(1);
        drop <= 8'h0;
        tick(6);
        rchk(12'h3c0, 32'h1);
        apb(1'b1, 12'h3c0, 32'h4);
        fire <= 8'h80;
        tick(1);
        fire <= 8'h0;
        tick(6);
        drop <= 8'h80;
        tick(1);
        drop <= 8'h0;
        tick(6);
        rchk(12'h3c0, 32'hc);
        vectorAck <= 2'b10;
        tick(1);
        vectorAck <= 2'b00;
        tick(2);
        rchk(12'h3c0, 32'h4);
        apb(1'b1, 12'h3c0, 32'hc);
        rchk(12'h3c0, 32'hc);
        give_verdict();
    end
endmodule
`default_nettype wire
